/* common/iopr_defines.vh */
// constants for the i/o port and reset pin block
// assumes inclusion by bare name from logic files
`ifndef IOPR_DEFINES_VH
`define IOPR_DEFINES_VH
`define IOPR_WIDE_W 8
`define IOPR_NARROW_W 4
`define IOPR_IO_ADDR_W 6
`define IOPR_BIT_ADDR_MAX 6'h1f
// i/o offsets of the port register groups
`define IOPR_WIDE_DATA 6'h1b
`define IOPR_WIDE_DIR 6'h1a
`define IOPR_WIDE_PIN 6'h19
`define IOPR_NARROW_DATA 6'h18
`define IOPR_NARROW_DIR 6'h17
`define IOPR_NARROW_PIN 6'h16
`define IOPR_FLAGS 6'h15
// single-bit operation codes
`define IOPR_OP_NONE 2'h0
`define IOPR_OP_SET 2'h1
`define IOPR_OP_CLR 2'h2
`define IOPR_OP_TEST 2'h3
// minimum reset pulse
`define IOPR_RST_MIN_NS 2500
`define IOPR_CLK_NS 100
`define IOPR_RST_CYC ((`IOPR_RST_MIN_NS + `IOPR_CLK_NS - 1) / `IOPR_CLK_NS)
`endif

/* logic/iopr_pin_bank.v */
// one bank of bidirectional pins with pull-up and direction
// assumes the pad ring resolves drive and pull from the enables
`timescale 1ns/1ns
module iopr_pin_bank #(
  parameter W = 8
) (
  // control
  input wire force_hiz,
  input wire [W-1:0] dir,
  input wire [W-1:0] data,
  // pads
  output wire [W-1:0] pad_out,
  output wire [W-1:0] pad_oe_n,
  output wire [W-1:0] pad_pullup
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // driver off while reset holds, no clock needed
      assign pad_oe_n[i] = force_hiz | ~dir[i]; // [RULE3] [RULE10]
      assign pad_out[i] = data[i];
      // pull-up only as input, never while tri-stated by reset
      assign pad_pullup[i] = ~force_hiz & ~dir[i] & data[i]; // [RULE10]
    end
  endgenerate
endmodule

/* logic/iopr_top.v */
// i/o ports, shared reset pin and bit-addressable i/o registers
// assumes a cpu core drives io_* ports synchronous to core_clk
`include "iopr_defines.vh"
`timescale 1ns/1ns
// How it works
// [RULE1] four-bit bidirectional port, each bit with its own pull-up select
// [RULE2] eight-bit bidirectional port, each bit with its own pull-up select
// [RULE3] any active reset tri-states every pin asynchronously, clock not needed; the pin reset is only seen through the clocked low counter
// [RULE4] top narrow bit is reset input unless the disable fuse reads zero
// [RULE5] low on enabled reset pin past minimum length resets the device
// [RULE6] addresses 0x00 to 0x1f allow single-bit set, clear and test
// [RULE7] status flags clear on writing one; writing zero leaves them
// [RULE8] a single-bit operation touches only the addressed bit
// [RULE9] software writes zero to reserved bits, never reserved addresses
// [RULE10] direction bit enables driver; pull-up only effective as input
module iopr_top #(
  parameter WIDE_W = `IOPR_WIDE_W,
  parameter NARROW_W = `IOPR_NARROW_W,
  parameter RST_CYC = `IOPR_RST_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // fuse and flag events
  input wire reset_disable_fuse,
  input wire [7:0] flag_events,
  // cpu i/o bus
  input wire [5:0] io_addr,
  input wire io_wr,
  input wire [7:0] io_wdata,
  input wire io_rd,
  output reg [7:0] io_rdata,
  input wire [1:0] io_bit_op,
  input wire [2:0] io_bit_sel,
  output wire io_bit_value,
  // wide port pads
  input wire [WIDE_W-1:0] wide_port_pins_in,
  output wire [WIDE_W-1:0] wide_port_pins_out,
  output wire [WIDE_W-1:0] wide_port_pins_oe_n,
  output wire [WIDE_W-1:0] wide_port_pins_pullup,
  // narrow port pads
  input wire [NARROW_W-1:0] narrow_port_pins_in,
  output wire [NARROW_W-1:0] narrow_port_pins_out,
  output wire [NARROW_W-1:0] narrow_port_pins_oe_n,
  output wire [NARROW_W-1:0] narrow_port_pins_pullup,
  // reset request from the pin
  output wire pin_reset_n
);
  ////////////////////////////////////////////////////////////////////////////
  reg [WIDE_W-1:0] wide_data;
  reg [WIDE_W-1:0] wide_dir;
  reg [NARROW_W-1:0] narrow_data;
  reg [NARROW_W-1:0] narrow_dir;
  reg [7:0] flags;
  reg [WIDE_W-1:0] wide_sync;
  reg [NARROW_W-1:0] narrow_sync;
  reg fuse_latched;
  reg [15:0] low_cnt;
  reg pin_rst_hold;
  wire shared_reset_pin;
  wire pin_is_reset;
  wire any_reset;
  wire [7:0] cur_val;
  wire [7:0] bit_mask;
  wire bit_ok;
  wire [15:0] rst_cyc_w;
  assign rst_cyc_w = RST_CYC;
  ////////////////////////////////////////////////////////////////////////////
  // fuse captured after release, default reset function
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fuse_latched <= 1'b1;
    end else begin
      fuse_latched <= reset_disable_fuse;
    end
  end
  assign shared_reset_pin = narrow_port_pins_in[NARROW_W-1];
  assign pin_is_reset = fuse_latched; // [RULE4]
  // low level counted; short glitches ignored
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 16'h0000;
      pin_rst_hold <= 1'b0;
    end else if (!pin_is_reset || shared_reset_pin) begin
      low_cnt <= 16'h0000;
      pin_rst_hold <= 1'b0;
    end else if (low_cnt < rst_cyc_w) begin
      low_cnt <= low_cnt + 16'h0001;
    end else begin
      pin_rst_hold <= 1'b1; // [RULE5]
    end
  end
  // pin_reset_n only follows the clocked low counter; nothing here drives rstn from the pad
  assign pin_reset_n = ~pin_rst_hold; // [RULE5]
  assign any_reset = ~rstn | pin_rst_hold; // [RULE3]
  ////////////////////////////////////////////////////////////////////////////
  // pin input sampling
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wide_sync <= {WIDE_W{1'b0}};
      narrow_sync <= {NARROW_W{1'b0}};
    end else begin
      wide_sync <= wide_port_pins_in;
      narrow_sync <= narrow_port_pins_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // current value of addressed register
  assign cur_val = (io_addr == `IOPR_WIDE_DATA) ? wide_data :
                   (io_addr == `IOPR_WIDE_DIR) ? wide_dir :
                   (io_addr == `IOPR_WIDE_PIN) ? wide_sync :
                   (io_addr == `IOPR_NARROW_DATA) ? {4'h0, narrow_data} :
                   (io_addr == `IOPR_NARROW_DIR) ? {4'h0, narrow_dir} :
                   (io_addr == `IOPR_NARROW_PIN) ? {4'h0, narrow_sync} :
                   (io_addr == `IOPR_FLAGS) ? flags : 8'h00;
  assign bit_mask = 8'h01 << io_bit_sel;
  assign bit_ok = (io_addr <= `IOPR_BIT_ADDR_MAX); // [RULE6]
  assign io_bit_value = bit_ok & (io_bit_op == `IOPR_OP_TEST) &
                        cur_val[io_bit_sel]; // [RULE6]
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= cur_val;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // writable port registers; bit ops modify only the chosen bit
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wide_data <= {WIDE_W{1'b0}};
      wide_dir <= {WIDE_W{1'b0}};
      narrow_data <= {NARROW_W{1'b0}};
      narrow_dir <= {NARROW_W{1'b0}};
    end else if (io_wr) begin
      case (io_addr)
        `IOPR_WIDE_DATA: wide_data <= io_wdata;
        `IOPR_WIDE_DIR: wide_dir <= io_wdata;
        `IOPR_NARROW_DATA: narrow_data <= io_wdata[3:0];
        `IOPR_NARROW_DIR: narrow_dir <= io_wdata[3:0];
        default: ;
      endcase
    end else if (bit_ok && io_bit_op == `IOPR_OP_SET) begin
      case (io_addr)
        `IOPR_WIDE_DATA: wide_data <= wide_data | bit_mask; // [RULE6] [RULE8]
        `IOPR_WIDE_DIR: wide_dir <= wide_dir | bit_mask; // [RULE6] [RULE8]
        `IOPR_NARROW_DATA: narrow_data <= narrow_data | bit_mask[3:0]; // [RULE8]
        `IOPR_NARROW_DIR: narrow_dir <= narrow_dir | bit_mask[3:0]; // [RULE8]
        default: ;
      endcase
    end else if (bit_ok && io_bit_op == `IOPR_OP_CLR) begin
      case (io_addr)
        `IOPR_WIDE_DATA: wide_data <= wide_data & ~bit_mask; // [RULE6] [RULE8]
        `IOPR_WIDE_DIR: wide_dir <= wide_dir & ~bit_mask; // [RULE6] [RULE8]
        `IOPR_NARROW_DATA: narrow_data <= narrow_data & ~bit_mask[3:0]; // [RULE8]
        `IOPR_NARROW_DIR: narrow_dir <= narrow_dir & ~bit_mask[3:0]; // [RULE8]
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // status flags: write one clears, events win over clear
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags <= 8'h00;
    end else if (io_addr == `IOPR_FLAGS && io_wr) begin
      flags <= (flags & ~io_wdata) | flag_events; // [RULE7]
    end else if (io_addr == `IOPR_FLAGS && io_bit_op == `IOPR_OP_SET) begin
      flags <= (flags & ~bit_mask) | flag_events; // [RULE8]
    end else begin
      flags <= flags | flag_events;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  wire [NARROW_W-1:0] narrow_oe_n_raw;
  iopr_pin_bank #(.W(WIDE_W)) u_wide (
    .force_hiz(any_reset),
    .dir(wide_dir),
    .data(wide_data),
    .pad_out(wide_port_pins_out),
    .pad_oe_n(wide_port_pins_oe_n),
    .pad_pullup(wide_port_pins_pullup)
  ); // [RULE2]
  iopr_pin_bank #(.W(NARROW_W)) u_narrow (
    .force_hiz(any_reset),
    .dir(narrow_dir),
    .data(narrow_data),
    .pad_out(narrow_port_pins_out),
    .pad_oe_n(narrow_oe_n_raw),
    .pad_pullup(narrow_port_pins_pullup)
  ); // [RULE1]
  // reset-function pin never driven
  assign narrow_port_pins_oe_n = narrow_oe_n_raw |
                                 {pin_is_reset, {(NARROW_W-1){1'b0}}}; // [RULE4]
endmodule

/* verification/iopr_top_chk_sva.sv */
// assertions on pads, pin reset and bit operations
// assumes bind onto iopr_top at default widths
`timescale 1ns/1ns
module iopr_top_chk #(parameter RST_CYC = 25) (
  // clock, reset, fuse
  input wire core_clk,
  input wire rstn,
  input wire reset_disable_fuse,
  // cpu side
  input wire [5:0] io_addr,
  input wire io_wr,
  input wire [7:0] io_wdata,
  input wire [1:0] io_bit_op,
  input wire [2:0] io_bit_sel,
  input wire io_bit_value,
  // pads
  input wire [7:0] wide_port_pins_out,
  input wire [7:0] wide_port_pins_oe_n,
  input wire [7:0] wide_port_pins_pullup,
  input wire [3:0] narrow_port_pins_in,
  input wire [3:0] narrow_port_pins_oe_n,
  input wire pin_reset_n
);
  reg [7:0] low_cnt;
  wire held = reset_disable_fuse && !narrow_port_pins_in[3];
  // length of the current low level on the reset pin
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) low_cnt <= 8'h0;
    else if (!held) low_cnt <= 8'h0;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_dir_wr; io_wr && io_addr == 6'h1a; endsequence
  sequence s_dir_set; pin_reset_n && !io_wr && io_bit_op == 2'h1 && io_addr == 6'h1a; endsequence
  chk_pin_hiz: assert property (!pin_reset_n |->
    &wide_port_pins_oe_n && &narrow_port_pins_oe_n) else $error("pin driven in reset");
  chk_dir_drive: assert property (s_dir_wr |=>
    !pin_reset_n || wide_port_pins_oe_n == ~$past(io_wdata)) else $error("dir write");
  chk_pull_input: assert property (pin_reset_n |->
    wide_port_pins_pullup == (wide_port_pins_out & wide_port_pins_oe_n)) else $error("pull");
  chk_bit_test: assert property (pin_reset_n && io_bit_op == 2'h3 && io_addr == 6'h1a |->
    io_bit_value == !wide_port_pins_oe_n[io_bit_sel]) else $error("bit test");
  chk_bit_only: assert property (s_dir_set |=> !pin_reset_n ||
    wide_port_pins_oe_n == ($past(wide_port_pins_oe_n) & ~(8'h1 << $past(io_bit_sel))))
    else $error("bit set");
  chk_fuse_gpio: assert property (!reset_disable_fuse [*4] |-> pin_reset_n)
    else $error("reset while disabled");
  chk_reset_input: assert property (reset_disable_fuse [*2] |-> narrow_port_pins_oe_n[3])
    else $error("reset pin driven");
  chk_pulse_len: assert property (low_cnt > RST_CYC + 2 |-> !pin_reset_n)
    else $error("no pin reset");
endmodule
bind iopr_top iopr_top_chk #(.RST_CYC(RST_CYC)) iopr_top_chk_i (.core_clk, .rstn,
  .reset_disable_fuse, .io_addr, .io_wr, .io_wdata, .io_bit_op, .io_bit_sel, .io_bit_value,
  .wide_port_pins_out, .wide_port_pins_oe_n, .wide_port_pins_pullup, .narrow_port_pins_in,
  .narrow_port_pins_oe_n, .pin_reset_n);

/* verification/iopr_board.sv */
// board model for one bank of pins
// assumes bench supplies external drive levels
`timescale 1ns/1ns
module iopr_board #(parameter W = 8) (
  // device pads
  input wire core_clk,
  input wire [W-1:0] out,
  input wire [W-1:0] oe_n,
  input wire [W-1:0] pu,
  // external drivers
  input wire [W-1:0] ext_en,
  input wire [W-1:0] ext_val,
  output wire [W-1:0] pins
);
  reg [W-1:0] drift = {W{1'b0}};
  always @(posedge core_clk) drift <= ~drift;
  // device, then board, then pull-up, else a floating level
  assign pins = (~oe_n & out) | (oe_n & ext_en & ext_val)
    | (oe_n & ~ext_en & (pu | drift));
endmodule

/* verification/test_io_ports_reset_pin.sv */
// self-checking bench for the port block
// assumes checker and board model compiled first
`timescale 1ns/1ns
module test_io_ports_reset_pin;
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg reset_disable_fuse = 1'b1;
  reg [7:0] flag_events = 8'h0;
  reg [5:0] io_addr = 6'h0;
  reg io_wr = 1'b0;
  reg io_rd = 1'b0;
  reg [7:0] io_wdata = 8'h0;
  reg [1:0] io_bit_op = 2'h0;
  reg [2:0] io_bit_sel = 3'h0;
  reg [7:0] w_en = 8'h5a;
  reg [7:0] w_val = 8'h50;
  reg [3:0] n_en = 4'h8;
  reg [3:0] n_val = 4'h8;
  wire [7:0] io_rdata, w_in, w_out, w_oe, w_pu;
  wire [3:0] n_in, n_out, n_oe, n_pu;
  wire io_bit_value, pin_reset_n;
  integer n_mismatch = 0;
  integer n_compared = 0;
  always #50 core_clk = ~core_clk;
  iopr_top #(.RST_CYC(5)) iopr_top_i (.core_clk, .rstn, .reset_disable_fuse, .flag_events,
    .io_addr, .io_wr, .io_wdata, .io_rd, .io_rdata, .io_bit_op, .io_bit_sel, .io_bit_value,
    .wide_port_pins_in(w_in), .wide_port_pins_out(w_out), .wide_port_pins_oe_n(w_oe),
    .wide_port_pins_pullup(w_pu), .narrow_port_pins_in(n_in), .narrow_port_pins_out(n_out),
    .narrow_port_pins_oe_n(n_oe), .narrow_port_pins_pullup(n_pu), .pin_reset_n);
  iopr_board #(.W(8)) iopr_board_i (.core_clk, .out(w_out), .oe_n(w_oe), .pu(w_pu),
    .ext_en(w_en), .ext_val(w_val), .pins(w_in));
  iopr_board #(.W(4)) iopr_board_n_i (.core_clk, .out(n_out), .oe_n(n_oe), .pu(n_pu),
    .ext_en(n_en), .ext_val(n_val), .pins(n_in));
  ////////////////////////////////
  task check(input string what, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task step; begin @(posedge core_clk); #5; end endtask
  task wr(input [5:0] a, input [7:0] d);
    begin io_addr = a; io_wdata = d; io_wr = 1'b1; step; io_wr = 1'b0; step; end
  endtask
  task rd(input [5:0] a, input [7:0] exp);
    begin io_addr = a; io_rd = 1'b1; step; io_rd = 1'b0; step; check("read", exp, io_rdata); end
  endtask
  task bop(input [1:0] op, input [5:0] a, input [2:0] s, input exp);
    begin
      io_bit_op = op; io_addr = a; io_bit_sel = s; #1;
      if (op == 2'h3) check("bit test", {7'h0, exp}, {7'h0, io_bit_value});
      step; io_bit_op = 2'h0; step;
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////
  initial begin
    repeat (6) step;
    check("wide hiz", 8'hff, w_oe);
    rstn = 1'b1;
    wr(6'h1b, 8'h3c); wr(6'h1a, 8'ha5); repeat (3) step;
    check("wide oe", 8'h5a, w_oe);
    check("wide out", 8'h24, w_out & 8'ha5);
    check("wide pull", 8'h18, w_pu);
    rd(6'h19, 8'h74);
    wr(6'h18, 8'h0d); wr(6'h17, 8'h07);
    check("narrow oe", 8'h08, {4'h0, n_oe});
    check("narrow pull", 8'h08, {4'h0, n_pu});
    check("narrow out", 8'h0d, {4'h0, n_out});
    rd(6'h17, 8'h07);
    bop(2'h1, 6'h1a, 3'h1, 1'b0); bop(2'h2, 6'h1a, 3'h7, 1'b0);
    bop(2'h1, 6'h3a, 3'h3, 1'b0); bop(2'h3, 6'h1a, 3'h1, 1'b1);
    rd(6'h1a, 8'h27);
    flag_events = 8'h07; step; flag_events = 8'h00; step;
    rd(6'h15, 8'h07); wr(6'h15, 8'h04); rd(6'h15, 8'h03);
    wr(6'h15, 8'h00); rd(6'h15, 8'h03);
    bop(2'h1, 6'h15, 3'h0, 1'b0); bop(2'h2, 6'h15, 3'h1, 1'b0); rd(6'h15, 8'h02);
    n_val = 4'h0; repeat (10) step;
    check("pin reset", 8'h00, {7'h0, pin_reset_n});
    check("hiz pin reset", 8'hff, w_oe);
    n_val = 4'h8; repeat (4) step;
    check("reset end", 8'h01, {7'h0, pin_reset_n});
    reset_disable_fuse = 1'b0; n_val = 4'h0; repeat (10) step;
    check("gpio pin", 8'h01, {7'h0, pin_reset_n});
    reset_disable_fuse = 1'b1; n_val = 4'h8;
    wr(6'h1a, 8'hff); check("all out", 8'h00, w_oe);
    #20; rstn = 1'b0; #1;
    check("async hiz", 8'hff, w_oe);
    step; rstn = 1'b1; rd(6'h1a, 8'h00);
    print_verdict;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
endmodule
